// ===== logic/coherent_req_unit.sv
`timescale 1ns/10ps
`default_nettype none

module coherent_req_unit (
    input  wire logic                           sys_clk,
    input  wire logic                           reset_n,
    input  wire logic                           req_valid,
    input  wire snoop_pkg::req_kind_t           req_kind,
    input  wire logic [snoop_pkg::AC_ADDR_W-1:0] req_addr,
    input  wire logic                           req_unique_held,
    output logic                                req_ready,
    output logic                                req_done,
    output logic                                ar_valid,
    input  wire logic                           ar_ready,
    output logic [snoop_pkg::AC_ADDR_W-1:0]     ar_addr,
    output logic [snoop_pkg::SNOOP_W-1:0]       ar_snoop,
    input  wire logic                           rd_resp_done,
    output logic                                store_go,
    input  wire logic                           store_done,
    input  wire logic                           wr_resp_done,
    output logic                                rack,
    output logic                                wack
);
    import snoop_pkg::*;

    typedef enum logic [1:0]
    {
        R_IDLE  = 2'b00,
        R_ADDR  = 2'b01,
        R_WAIT  = 2'b10,
        R_STORE = 2'b11
    } req_state_t;

    req_state_t            state_q;
    req_state_t            state_d;
    req_kind_t             kind_q;
    req_kind_t             kind_d;
    logic                  no_tx_q;
    logic                  no_tx_d;
    logic                  req_ready_q;
    logic                  req_ready_d;
    logic                  req_done_q;
    logic                  req_done_d;
    logic                  ar_valid_q;
    logic                  ar_valid_d;
    logic [AC_ADDR_W-1:0]  ar_addr_q;
    logic [AC_ADDR_W-1:0]  ar_addr_d;
    logic [SNOOP_W-1:0]    ar_snoop_q;
    logic [SNOOP_W-1:0]    ar_snoop_d;
    logic                  store_go_q;
    logic                  store_go_d;
    logic                  rack_q;
    logic                  rack_d;
    logic                  wack_q;
    logic                  wack_d;

    always_comb
    begin
        state_d     = state_q;
        kind_d      = kind_q;
        no_tx_d     = no_tx_q;
        req_ready_d = 1'b0;
        req_done_d  = 1'b0;
        ar_valid_d  = ar_valid_q;
        ar_addr_d   = ar_addr_q;
        ar_snoop_d  = ar_snoop_q;
        store_go_d  = 1'b0;
        rack_d      = 1'b0;
        wack_d      = wr_resp_done;
        case (state_q)
            R_IDLE:
            begin
                req_ready_d = ~(req_valid & req_ready_q);
                if (req_valid && req_ready_q)
                begin
                    kind_d = req_kind;
                    if (req_kind != REQ_LOAD && req_unique_held)
                    begin
                        // A unique line is stored to with no broadcast.
                        no_tx_d    = 1'b1;
                        store_go_d = 1'b1;
                        state_d    = R_STORE;
                    end
                    else
                    begin
                        no_tx_d    = 1'b0;
                        ar_valid_d = 1'b1;
                        ar_addr_d  = req_addr;
                        case (req_kind)
                            REQ_PART_STORE: ar_snoop_d = AR_READ_UNIQUE_OP;
                            REQ_FULL_STORE: ar_snoop_d = AR_MAKE_UNIQUE_OP;
                            default:        ar_snoop_d = AR_READ_SHARED_OP;
                        endcase
                        state_d = R_ADDR;
                    end
                end
            end
            R_ADDR:
            begin
                if (ar_ready)
                begin
                    ar_valid_d = 1'b0;
                    state_d    = R_WAIT;
                end
            end
            R_WAIT:
            begin
                if (rd_resp_done)
                begin
                    if (kind_q == REQ_LOAD)
                    begin
                        rack_d     = 1'b1;
                        req_done_d = 1'b1;
                        state_d    = R_IDLE;
                    end
                    else
                    begin
                        // Other copies are gone once the unique response is in.
                        store_go_d = 1'b1;
                        state_d    = R_STORE;
                    end
                end
            end
            R_STORE:
            begin
                if (store_done)
                begin
                    rack_d     = ~no_tx_q;
                    req_done_d = 1'b1;
                    state_d    = R_IDLE;
                end
            end
            default:
            begin
                state_d = R_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q     <= R_IDLE;
            kind_q      <= REQ_LOAD;
            no_tx_q     <= 1'b0;
            req_ready_q <= 1'b0;
            req_done_q  <= 1'b0;
            ar_valid_q  <= 1'b0;
            ar_addr_q   <= '0;
            ar_snoop_q  <= '0;
            store_go_q  <= 1'b0;
            rack_q      <= 1'b0;
            wack_q      <= 1'b0;
        end
        else
        begin
            state_q     <= state_d;
            kind_q      <= kind_d;
            no_tx_q     <= no_tx_d;
            req_ready_q <= req_ready_d;
            req_done_q  <= req_done_d;
            ar_valid_q  <= ar_valid_d;
            ar_addr_q   <= ar_addr_d;
            ar_snoop_q  <= ar_snoop_d;
            store_go_q  <= store_go_d;
            rack_q      <= rack_d;
            wack_q      <= wack_d;
        end
    end

    assign req_ready = req_ready_q;
    assign req_done  = req_done_q;
    assign ar_valid  = ar_valid_q;
    assign ar_addr   = ar_addr_q;
    assign ar_snoop  = ar_snoop_q;
    assign store_go  = store_go_q;
    assign rack      = rack_q;
    assign wack      = wack_q;
endmodule

`default_nettype wire

// ===== logic/coherent_snoop_port.sv
// Functional notes
// - Snoop address in: valid, address, opcode, protection.
// - Exactly one response per accepted snoop.
// - Response carries flag announcing following data.
// - Optional snoop data: valid, data, last.
// - Drive read and write acknowledge outputs.
// - Holder responds and supplies line on data; the code sends no data for the two pure invalidation snoops.
// - Load done: assert read acknowledge.
// - All other copies removed before shareable store.
// - Partial store of missing line issues ReadUnique.
// - Unique line: stores need no broadcast.
// - Full-line store issues MakeUnique.
// - Invalidating snoop answered with removal response.
// - Store then read acknowledge after unique response.
`timescale 1ns/10ps
`default_nettype none

module coherent_snoop_port (
    input  wire logic                            sys_clk,
    input  wire logic                            reset_n,
    input  wire logic                            ac_valid,
    output logic                                 ac_ready,
    input  wire logic [snoop_pkg::AC_ADDR_W-1:0] ac_addr,
    input  wire logic [snoop_pkg::SNOOP_W-1:0]   ac_snoop,
    input  wire logic [snoop_pkg::PROT_W-1:0]    ac_prot,
    output logic                                 cr_valid,
    input  wire logic                            cr_ready,
    output logic [snoop_pkg::CRRESP_W-1:0]       cr_resp,
    output logic                                 cd_valid,
    input  wire logic                            cd_ready,
    output logic [snoop_pkg::CD_DATA_W-1:0]      cd_data,
    output logic                                 cd_last,
    output logic                                 lk_valid,
    output logic [snoop_pkg::AC_ADDR_W-1:0]      lk_addr,
    output logic [snoop_pkg::SNOOP_W-1:0]        lk_snoop,
    output logic [snoop_pkg::PROT_W-1:0]         lk_prot,
    output logic                                 lk_invalidate,
    input  wire logic                            lk_done,
    input  wire logic                            lk_has_data,
    input  wire logic                            lk_dirty,
    input  wire logic                            lk_keep,
    input  wire logic                            lk_was_unique,
    input  wire logic                            line_valid,
    input  wire logic [snoop_pkg::CD_DATA_W-1:0] line_data,
    output logic                                 line_ready,
    input  wire logic                            req_valid,
    input  wire snoop_pkg::req_kind_t            req_kind,
    input  wire logic [snoop_pkg::AC_ADDR_W-1:0] req_addr,
    input  wire logic                            req_unique_held,
    output logic                                 req_ready,
    output logic                                 req_done,
    output logic                                 ar_valid,
    input  wire logic                            ar_ready,
    output logic [snoop_pkg::AC_ADDR_W-1:0]      ar_addr,
    output logic [snoop_pkg::SNOOP_W-1:0]        ar_snoop,
    input  wire logic                            rd_resp_done,
    output logic                                 store_go,
    input  wire logic                            store_done,
    input  wire logic                            wr_resp_done,
    output logic                                 rack,
    output logic                                 wack
);
    import snoop_pkg::*;

    typedef enum logic [1:0]
    {
        S_IDLE   = 2'b00,
        S_LOOKUP = 2'b01,
        S_RESP   = 2'b10,
        S_DATA   = 2'b11
    } snoop_state_t;

    // Snoops of the pure invalidation kind never return data.
    function automatic logic snoop_invalidates(input logic [SNOOP_W-1:0] op);
        snoop_invalidates = (op == SNP_CLEAN_INVALID_OP) || (op == SNP_MAKE_INVALID_OP);
    endfunction

    snoop_state_t          state_q;
    snoop_state_t          state_d;
    logic                  ac_ready_q;
    logic                  ac_ready_d;
    logic                  lk_valid_q;
    logic                  lk_valid_d;
    logic [AC_ADDR_W-1:0]  lk_addr_q;
    logic [AC_ADDR_W-1:0]  lk_addr_d;
    logic [SNOOP_W-1:0]    lk_snoop_q;
    logic [SNOOP_W-1:0]    lk_snoop_d;
    logic [PROT_W-1:0]     lk_prot_q;
    logic [PROT_W-1:0]     lk_prot_d;
    logic                  lk_inval_q;
    logic                  lk_inval_d;
    logic                  cr_valid_q;
    logic                  cr_valid_d;
    logic [CRRESP_W-1:0]   cr_resp_q;
    logic [CRRESP_W-1:0]   cr_resp_d;
    logic                  data_due_q;
    logic                  data_due_d;
    logic [BEAT_CNT_W-1:0] beats_q;
    logic [BEAT_CNT_W-1:0] beats_d;
    logic                  cd_valid_q;
    logic                  cd_valid_d;
    logic [CD_DATA_W-1:0]  cd_data_q;
    logic [CD_DATA_W-1:0]  cd_data_d;
    logic                  cd_last_q;
    logic                  cd_last_d;
    logic                  cd_free;
    logic                  pop;
    logic                  send_data;

    stream_if #(.W(CD_DATA_W)) fill_s ();
    stream_if #(.W(CD_DATA_W)) drain_s ();

    // The cache may stream the line in before the response is taken; the buffer
    // absorbs it, and a full buffer holds off the cache through line_ready.
    assign fill_s.valid = line_valid;
    assign fill_s.data  = line_data;
    assign line_ready   = fill_s.ready;

    snoop_fifo #(
        .WIDTH (CD_DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) data_buf (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .in_s    (fill_s),
        .out_s   (drain_s)
    );

    // The output stage may load a new beat when it is empty or being taken.
    assign cd_free       = ~cd_valid_q | cd_ready;
    assign pop           = (state_q == S_DATA) && (beats_q != NO_BEATS_LEFT)
                           && drain_s.valid && cd_free;
    assign drain_s.ready = pop;

    // A hit only yields data when the snoop is not a pure invalidation.
    assign send_data = lk_has_data & ~lk_inval_q;

    always_comb
    begin
        state_d    = state_q;
        ac_ready_d = 1'b0;
        lk_valid_d = lk_valid_q;
        lk_addr_d  = lk_addr_q;
        lk_snoop_d = lk_snoop_q;
        lk_prot_d  = lk_prot_q;
        lk_inval_d = lk_inval_q;
        cr_valid_d = cr_valid_q;
        cr_resp_d  = cr_resp_q;
        data_due_d = data_due_q;
        beats_d    = beats_q;
        case (state_q)
            S_IDLE:
            begin
                // Ready drops in the cycle after a snoop is taken, so only one
                // snoop is in flight and each gets exactly one response.
                ac_ready_d = ~(ac_valid & ac_ready_q);
                if (ac_valid && ac_ready_q)
                begin
                    lk_valid_d = 1'b1;
                    lk_addr_d  = ac_addr;
                    lk_snoop_d = ac_snoop;
                    lk_prot_d  = ac_prot;
                    lk_inval_d = snoop_invalidates(ac_snoop);
                    state_d    = S_LOOKUP;
                end
            end
            S_LOOKUP:
            begin
                if (lk_done)
                begin
                    lk_valid_d = 1'b0;
                    cr_valid_d = 1'b1;
                    cr_resp_d  = '0;
                    cr_resp_d[CR_DATA_XFER_BIT]  = send_data;
                    cr_resp_d[CR_PASS_DIRTY_BIT] = send_data & lk_dirty;
                    cr_resp_d[CR_IS_SHARED_BIT]  = lk_keep & ~lk_inval_q;
                    cr_resp_d[CR_WAS_UNIQUE_BIT] = lk_was_unique;
                    data_due_d = send_data;
                    state_d    = S_RESP;
                end
            end
            S_RESP:
            begin
                if (cr_ready)
                begin
                    cr_valid_d = 1'b0;
                    if (data_due_q)
                    begin
                        beats_d = LINE_BEATS;
                        state_d = S_DATA;
                    end
                    else
                    begin
                        state_d = S_IDLE;
                    end
                end
            end
            S_DATA:
            begin
                if (pop)
                begin
                    beats_d = BEAT_CNT_W'(beats_q - 1'b1);
                end
                if (cd_valid_q && cd_ready && cd_last_q)
                begin
                    data_due_d = 1'b0;
                    state_d    = S_IDLE;
                end
            end
            default:
            begin
                state_d = S_IDLE;
            end
        endcase
    end

    always_comb
    begin
        cd_valid_d = cd_valid_q;
        cd_data_d  = cd_data_q;
        cd_last_d  = cd_last_q;
        if (cd_free)
        begin
            cd_valid_d = pop;
            if (pop)
            begin
                cd_data_d = drain_s.data;
                cd_last_d = (beats_q == LAST_BEAT_LEFT);
            end
            else
            begin
                cd_last_d = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q    <= S_IDLE;
            ac_ready_q <= 1'b0;
            lk_valid_q <= 1'b0;
            lk_addr_q  <= '0;
            lk_snoop_q <= '0;
            lk_prot_q  <= '0;
            lk_inval_q <= 1'b0;
            cr_valid_q <= 1'b0;
            cr_resp_q  <= '0;
            data_due_q <= 1'b0;
            beats_q    <= NO_BEATS_LEFT;
        end
        else
        begin
            state_q    <= state_d;
            ac_ready_q <= ac_ready_d;
            lk_valid_q <= lk_valid_d;
            lk_addr_q  <= lk_addr_d;
            lk_snoop_q <= lk_snoop_d;
            lk_prot_q  <= lk_prot_d;
            lk_inval_q <= lk_inval_d;
            cr_valid_q <= cr_valid_d;
            cr_resp_q  <= cr_resp_d;
            data_due_q <= data_due_d;
            beats_q    <= beats_d;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cd_valid_q <= 1'b0;
            cd_data_q  <= '0;
            cd_last_q  <= 1'b0;
        end
        else
        begin
            cd_valid_q <= cd_valid_d;
            cd_data_q  <= cd_data_d;
            cd_last_q  <= cd_last_d;
        end
    end

    // Requests from the local cache: coherent loads and shareable stores.
    coherent_req_unit req_unit (
        .sys_clk         (sys_clk),
        .reset_n         (reset_n),
        .req_valid       (req_valid),
        .req_kind        (req_kind),
        .req_addr        (req_addr),
        .req_unique_held (req_unique_held),
        .req_ready       (req_ready),
        .req_done        (req_done),
        .ar_valid        (ar_valid),
        .ar_ready        (ar_ready),
        .ar_addr         (ar_addr),
        .ar_snoop        (ar_snoop),
        .rd_resp_done    (rd_resp_done),
        .store_go        (store_go),
        .store_done      (store_done),
        .wr_resp_done    (wr_resp_done),
        .rack            (rack),
        .wack            (wack)
    );

    assign ac_ready      = ac_ready_q;
    assign lk_valid      = lk_valid_q;
    assign lk_addr       = lk_addr_q;
    assign lk_snoop      = lk_snoop_q;
    assign lk_prot       = lk_prot_q;
    assign lk_invalidate = lk_inval_q;
    assign cr_valid      = cr_valid_q;
    assign cr_resp       = cr_resp_q;
    assign cd_valid      = cd_valid_q;
    assign cd_data       = cd_data_q;
    assign cd_last       = cd_last_q;
endmodule

`default_nettype wire

// ===== logic/snoop_fifo.sv
`timescale 1ns/10ps
`default_nettype none

module snoop_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    input  wire logic sys_clk,
    input  wire logic reset_n,
    stream_if.snk     in_s,
    stream_if.src     out_s
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr_q;
    logic [PW-1:0]    wr_ptr_d;
    logic [PW-1:0]    rd_ptr_q;
    logic [PW-1:0]    rd_ptr_d;
    logic [PW:0]      count_q;
    logic [PW:0]      count_d;
    logic             full_q;
    logic             full_d;
    logic             push;
    logic             pop;

    // Ready comes from a register so a full buffer stalls the cache cleanly.
    assign in_s.ready  = ~full_q;
    assign out_s.valid = (count_q != '0);
    assign out_s.data  = mem[rd_ptr_q];
    assign push        = in_s.valid & ~full_q;
    assign pop         = out_s.valid & out_s.ready;

    always_comb
    begin
        wr_ptr_d = push ? PW'(wr_ptr_q + 1'b1) : wr_ptr_q;
        rd_ptr_d = pop ? PW'(rd_ptr_q + 1'b1) : rd_ptr_q;
        count_d  = count_q;
        if (push && !pop)
        begin
            count_d = (PW+1)'(count_q + 1'b1);
        end
        else if (pop && !push)
        begin
            count_d = (PW+1)'(count_q - 1'b1);
        end
        full_d = (count_d == (PW+1)'(DEPTH));
    end

    always_ff @(posedge sys_clk)
    begin
        if (push)
        begin
            mem[wr_ptr_q] <= in_s.data;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
            full_q   <= 1'b0;
        end
        else
        begin
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            count_q  <= count_d;
            full_q   <= full_d;
        end
    end
endmodule

`default_nettype wire

// ===== logic/snoop_pkg.sv
`default_nettype none

package snoop_pkg;

    // Channel widths.
    localparam int AC_ADDR_W  = 32;
    localparam int SNOOP_W    = 4;
    localparam int PROT_W     = 3;
    localparam int CRRESP_W   = 5;
    localparam int CD_DATA_W  = 32;

    // A cache line is sixteen beats of snoop data.
    localparam int         LINE_BEATS_INT = 16;
    localparam int         BEAT_CNT_W     = 5;
    localparam logic [4:0] LINE_BEATS     = 5'h10;
    localparam logic [4:0] LAST_BEAT_LEFT = 5'h01;
    localparam logic [4:0] NO_BEATS_LEFT  = 5'h00;

    // Depth of the snoop data buffer in words.
    localparam int FIFO_DEPTH = 32;

    // Bit positions inside the snoop response.
    localparam int CR_DATA_XFER_BIT = 0;
    localparam int CR_ERROR_BIT     = 1;
    localparam int CR_PASS_DIRTY_BIT = 2;
    localparam int CR_IS_SHARED_BIT = 3;
    localparam int CR_WAS_UNIQUE_BIT = 4;

    // Read address opcodes issued by the requester.
    localparam logic [3:0] AR_READ_SHARED_OP = 4'h1;
    localparam logic [3:0] AR_READ_UNIQUE_OP = 4'h2;
    localparam logic [3:0] AR_MAKE_UNIQUE_OP = 4'h3;

    // Snoop opcodes that only remove the line and never carry data.
    localparam logic [3:0] SNP_CLEAN_INVALID_OP = 4'h9;
    localparam logic [3:0] SNP_MAKE_INVALID_OP  = 4'hD;

    typedef enum logic [1:0]
    {
        REQ_LOAD       = 2'b00,
        REQ_PART_STORE = 2'b01,
        REQ_FULL_STORE = 2'b10
    } req_kind_t;

endpackage

`default_nettype wire

// ===== logic/stream_if.sv
`timescale 1ns/10ps
`default_nettype none

interface stream_if #(parameter int W = 32);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

// ===== test/interconnect_model.sv
`timescale 1ns/10ps
`default_nettype none
module interconnect_model (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic stall,
    output logic     cr_ready,
    output logic     cd_ready
);
    logic t_q;
    // A stalling interconnect accepts on alternate edges so every hold is exercised.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        t_q <= reset_n && !t_q;
        cr_ready <= reset_n && (!stall || t_q);
        cd_ready <= reset_n && (!stall || !t_q);
    end
endmodule
`default_nettype wire

// ===== test/snoop_checker.sv
`timescale 1ns/10ps
`default_nettype none
module snoop_checker
    import snoop_pkg::*;
(
    input wire logic sys_clk, reset_n, ac_valid, ac_ready, cr_valid, cr_ready,
    input wire logic cd_valid, cd_ready, cd_last, lk_valid, lk_done,
    input wire logic wr_resp_done, wack, rack, req_done,
    input wire logic [CRRESP_W-1:0] cr_resp,
    input wire logic [CD_DATA_W-1:0] cd_data
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    snoop_take_a:
        assert property (ac_valid && ac_ready |=> lk_valid && !ac_ready) else $error("take");
    lookup_answer_a:
        assert property (lk_valid && lk_done |=> cr_valid && !lk_valid) else $error("lookup");
    resp_once_a:
        assert property (cr_valid && cr_ready |=> !cr_valid) else $error("resp twice");
    resp_hold_a:
        assert property (cr_valid && !cr_ready |=> cr_valid && $stable(cr_resp)) else $error("cr");
    data_hold_a:
        assert property (cd_valid && !cd_ready |=> cd_valid && $stable({cd_last, cd_data}))
        else $error("cd");
    data_after_a:
        assert property (cr_valid |-> !cd_valid) else $error("data early");
    wack_pulse_a:
        assert property (wr_resp_done |=> wack) else $error("wack");
    rack_done_a:
        assert property (rack |-> req_done) else $error("rack");
endmodule
bind coherent_snoop_port snoop_checker u_chk (.*);
`default_nettype wire

// ===== test/test_coherent_snoop_channels.sv
`timescale 1ns/10ps
`default_nettype none
module test_coherent_snoop_channels;
    import snoop_pkg::*;
    logic sys_clk = 0, reset_n = 0, ac_valid = 0, lk_done = 0, lk_has_data = 0, lk_dirty = 0;
    logic lk_keep = 0, lk_was_unique = 0, line_valid = 0, req_valid = 0, req_unique_held = 0;
    logic ar_ready = 0, rd_resp_done = 0, store_done = 0, wr_resp_done = 0, stall = 0;
    logic [31:0] ac_addr = 0, line_data = 0, req_addr = 0, cd_data, ar_addr, lk_addr;
    logic [3:0] ac_snoop = 0, ar_snoop, lk_snoop;
    logic [2:0] ac_prot = 0, lk_prot;
    logic [4:0] cr_resp;
    logic ac_ready, cr_valid, cr_ready, cd_valid, cd_ready, cd_last, lk_valid, lk_invalidate;
    logic line_ready, req_ready, req_done, ar_valid, store_go, rack, wack;
    req_kind_t req_kind = REQ_LOAD;
    int errors = 0, n_tests = 0, cyc = 0;
    coherent_snoop_port u_dut (.*);
    interconnect_model u_ic (.*);
    always #50 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
        if (++cyc == 5000)
        begin
            errors++;
            wrap_up;
        end
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic snoop(input logic [3:0] op, input logic hd, dt, kp, wu);
        logic inv;
        inv = (op == SNP_CLEAN_INVALID_OP) || (op == SNP_MAKE_INVALID_OP);
        @(posedge sys_clk);
        ac_valid <= 1;
        ac_snoop <= op;
        ac_addr <= 32'h8000_0040 + op;
        ac_prot <= op[2:0];
        do @(posedge sys_clk); while (!ac_ready);
        ac_valid <= 0;
        for (int i = 0; i < 16; i++)
        begin
            line_valid <= hd && !inv;
            line_data <= 32'hC0DE_0000 + i;
            do @(posedge sys_clk); while (!line_ready && hd && !inv);
        end
        line_valid <= 0;
        {lk_has_data, lk_dirty, lk_keep, lk_was_unique} <= {hd, dt, kp, wu};
        while (!lk_valid) @(posedge sys_clk);
        chk(lk_invalidate, inv);
        chk(lk_addr, 32'h8000_0040 + op);
        chk({lk_prot, lk_snoop}, {op[2:0], op});
        lk_done <= 1;
        @(posedge sys_clk);
        lk_done <= 0;
        do @(posedge sys_clk); while (!(cr_valid && cr_ready));
        chk(cr_resp, {wu, kp && !inv, hd && dt && !inv, 1'b0, hd && !inv});
        for (int i = 0; i < 16 && hd && !inv; i++)
        begin
            do @(posedge sys_clk); while (!(cd_valid && cd_ready));
            chk({cd_last, cd_data}, {i == 15, 32'hC0DE_0000 + i});
        end
    endtask
    task automatic req(input req_kind_t k, input logic held, input logic [3:0] op);
        @(posedge sys_clk);
        req_valid <= 1;
        req_kind <= k;
        req_unique_held <= held;
        req_addr <= {30'h1000_0000, k};
        do @(posedge sys_clk); while (!req_ready);
        req_valid <= 0;
        if (!held)
        begin
            while (!ar_valid) @(posedge sys_clk);
            chk(ar_snoop, op);
            chk(ar_addr, {30'h1000_0000, k});
            ar_ready <= 1;
            @(posedge sys_clk);
            ar_ready <= 0;
            rd_resp_done <= 1;
            @(posedge sys_clk);
            rd_resp_done <= 0;
        end
        if (k != REQ_LOAD)
        begin
            do @(posedge sys_clk); while (!store_go);
            store_done <= 1;
            @(posedge sys_clk);
            store_done <= 0;
        end
        do @(posedge sys_clk); while (!req_done);
        chk(rack, !held);
    endtask
    task automatic t_snoops;
        stall <= 1;
        snoop(4'h1, 1, 1, 1, 1);
        stall <= 0;
        snoop(SNP_CLEAN_INVALID_OP, 1, 1, 0, 1);
        snoop(SNP_MAKE_INVALID_OP, 0, 0, 0, 0);
        snoop(4'h1, 0, 0, 1, 0);
        $display("snoop test done");
    endtask
    task automatic t_reqs;
        req(REQ_LOAD, 0, AR_READ_SHARED_OP);
        req(REQ_PART_STORE, 0, AR_READ_UNIQUE_OP);
        req(REQ_FULL_STORE, 0, AR_MAKE_UNIQUE_OP);
        req(REQ_FULL_STORE, 1, 4'h0);
        $display("request test done");
    endtask
    task automatic t_wack;
        @(posedge sys_clk);
        wr_resp_done <= 1;
        @(posedge sys_clk);
        wr_resp_done <= 0;
        @(posedge sys_clk);
        chk(wack, 1);
        @(posedge sys_clk);
        chk(wack, 0);
        $display("write ack test done");
    endtask
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(posedge sys_clk);
        reset_n <= 1;
        repeat (2) @(posedge sys_clk);
        t_snoops;
        t_reqs;
        t_wack;
        wrap_up;
    end
endmodule
`default_nettype wire
